// ---- rtl/acrb_register_bank.v ----
// acrb_register_bank.v: configuration and calibration register bank with serial command port
// assumes sclk, din, csN, startPin, resetPowerdownN, clkSourceExt are asynchronous pins;
// data-ready and the out-of-range bit arrive from the conversion datapath on sys_clk
//
// Overview of operation
// - config 0 bit 7 reads one, bit 6 zero; reserved bits read zero
// - identity bits 5-4 are fixed and writes leave them unchanged
// - reference bias enable at config 0 bit 2, resets to one
// - config 0 bit 0 enables timeout after 65536 clocks of low serial clock
// - flag bit puts out-of-range in result lsb and checksum bit 7
// - config 1 bit 6 appends a checksum byte to each readback
// - config 1 bit 4 picks first or second order sinc filter
// - config 1 bit 3 picks external reference, resets to one
// - start delay code: zero none, else 64 doubling up to 4096 clocks
// - config 2 bit 7 mirrors the data-ready pin, low means ready
// - config 2 bit 6 reports the clock source read-only
// - config 2 bit 5 enables sync clock output, else driven low
// - config 2 bit 4 selects gate or pulse conversion control
// - config 2 bits 2-0 select one of eight output data rates
// - offset word in addresses 3 to 5, lsb first, resets zero
// - gain word in addresses 6 to 8, top byte resets to 40h
// - data output released while chip select is high
// - ready bit, and data output when idle in continuous read mode, also signal result availability
// - read opcode 0010 rrrr, write 0100 rrrr, second byte count minus one
`timescale 1ns/1ps
`include "acrb_defs.vh"

module acrb_register_bank #(
    parameter [1:0]  IDENTITY_FIELD  = 2'h1,   // arbitrary value
    parameter [16:0] TIMEOUT_CYCLES  = `ACRB_TIMEOUT_CYCLES
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        csN,
    input  wire        sclk,
    input  wire        din,
    input  wire        startPin,
    input  wire        resetPowerdownN,
    input  wire        clkSourceExt,
    input  wire        resultReadyN,
    input  wire        outOfRange,
    output reg         doutO,
    output reg         doutOeN,
    output reg         syncClockOutput,
    output reg         refBiasEnable,
    output reg         timeoutEnable,
    output reg         flagEnable,
    output reg         sumByteEnable,
    output reg         filterOrderSelect,
    output reg         outsideRefSelect,
    output reg  [2:0]  startDelayCode,
    output reg  [12:0] startDelayCycles,
    output reg         pulseControl,
    output reg  [2:0]  outputRateCode,
    output reg  [23:0] offsetCorrectionWord,
    output reg  [23:0] gainCorrectionWord,
    output reg         startLevel,
    output reg         powerdown,
    output reg         continuousRead,
    output reg         spiTimeout
);

    localparam ST_OP1  = 2'h0;
    localparam ST_OP2  = 2'h1;
    localparam ST_DATA = 2'h2;

    // register storage, nine bytes
    reg  [7:0]  regs [0:8];

    // two-flop synchronisers for every pin
    reg  [5:0]  syncA;
    reg  [5:0]  syncB;
    reg         sclkPrev;
    reg  [2:0]  bitCount;
    reg  [7:0]  shiftIn;
    reg  [7:0]  shiftOut;
    reg  [1:0]  state;
    reg         isWrite;
    reg  [3:0]  addr;
    reg  [3:0]  remain;
    reg  [16:0] lowCount;
    reg  [1:0]  syncDiv;
    integer     i;

    wire        csNS   = syncB[0];
    wire        sclkS  = syncB[1];
    wire        dinS   = syncB[2];
    wire        sclkRise = sclkS & ~sclkPrev;
    wire        sclkFall = ~sclkS & sclkPrev;
    wire [7:0]  byteIn = {shiftIn[6:0], dinS};
    wire        byteDone = sclkFall & ~csNS & (bitCount == 3'h7);
    wire        cmdReset = (byteIn[7:1] == `ACRB_CMD_RESET_HI);

    // read view of a register: read-only bits come live or fixed
    function [7:0] read_view;
        input [3:0] a;
        begin
            case (a)
                `ACRB_ADDR_CFG0: read_view = {2'b10, IDENTITY_FIELD,
                                              regs[0][3:0] & 4'h5};
                `ACRB_ADDR_CFG2: read_view = {resultReadyN, syncB[5],
                                              regs[2][5:0] & 6'h37};
                default:         read_view = (a <= `ACRB_LAST_ADDR) ? regs[a] : 8'h00;
            endcase
        end
    endfunction

    // write mask per address keeps read-only and reserved bits untouched
    function [7:0] write_mask;
        input [3:0] a;
        begin
            case (a)
                `ACRB_ADDR_CFG0: write_mask = `ACRB_CFG0_WMASK;
                `ACRB_ADDR_CFG1: write_mask = `ACRB_CFG1_WMASK;
                `ACRB_ADDR_CFG2: write_mask = `ACRB_CFG2_WMASK;
                default:         write_mask = (a <= `ACRB_LAST_ADDR) ? 8'hff : 8'h00;
            endcase
        end
    endfunction

    // pins pass two flops; nothing but the second stage reads the first
    // reset values match the idle pin levels (deselected, power-down pin high) so that
    // no false power-down pulse or edge follows reset
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncA <= 6'h11;
            syncB <= 6'h11;
        end else begin
            syncA <= {clkSourceExt, resetPowerdownN, startPin, din, sclk, csN};
            syncB <= syncA;
        end
    end

    // serial engine, register file and command handling
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regs[0]   <= `ACRB_CFG0_RST;
            regs[1]   <= `ACRB_CFG1_RST;
            regs[2]   <= `ACRB_CFG2_RST;
            for (i = 3; i < 8; i = i + 1)
                regs[i] <= `ACRB_ZERO_RST;
            regs[8]   <= `ACRB_GAIN_HIGH_RST;
            sclkPrev  <= 1'b0;
            bitCount  <= 3'h0;
            shiftIn   <= 8'h00;
            shiftOut  <= 8'h00;
            state     <= ST_OP1;
            isWrite   <= 1'b0;
            addr      <= 4'h0;
            remain    <= 4'h0;
            lowCount  <= 17'h00000;
            continuousRead <= 1'b1;
            spiTimeout <= 1'b0;
        end else begin
            sclkPrev   <= sclkS;
            spiTimeout <= 1'b0;
            // timeout counts clocks of low serial clock while selected
            if (sclkS | csNS)
                lowCount <= 17'h00000;
            else if (lowCount != TIMEOUT_CYCLES)
                lowCount <= lowCount + 17'h00001;
            if (csNS || (regs[0][0] && lowCount == TIMEOUT_CYCLES)) begin
                spiTimeout <= ~csNS;
                bitCount   <= 3'h0;
                state      <= ST_OP1;
                lowCount   <= 17'h00000;
            end else begin
                if (sclkFall) begin
                    shiftIn  <= byteIn;
                    bitCount <= bitCount + 3'h1;
                end
                // data shifts out on rising edges, msb first
                if (sclkRise && bitCount != 3'h0)
                    shiftOut <= {shiftOut[6:0], 1'b0};
                if (byteDone) begin
                    case (state)
                        ST_OP1: begin
                            if (byteIn == `ACRB_CMD_STOP_CONT)
                                continuousRead <= 1'b0;
                            else if (byteIn == `ACRB_CMD_CONT)
                                continuousRead <= 1'b1;
                            else if (cmdReset) begin
                                regs[0] <= `ACRB_CFG0_RST;
                                regs[1] <= `ACRB_CFG1_RST;
                                regs[2] <= `ACRB_CFG2_RST;
                                for (i = 3; i < 8; i = i + 1)
                                    regs[i] <= `ACRB_ZERO_RST;
                                regs[8] <= `ACRB_GAIN_HIGH_RST;
                            end else if (!continuousRead &&
                                         (byteIn[7:4] == `ACRB_CMD_READ ||
                                          byteIn[7:4] == `ACRB_CMD_WRITE)) begin
                                isWrite <= (byteIn[7:4] == `ACRB_CMD_WRITE);
                                addr    <= byteIn[3:0];
                                state   <= ST_OP2;
                            end
                        end
                        ST_OP2: begin
                            remain   <= byteIn[3:0];
                            shiftOut <= read_view(addr);
                            state    <= ST_DATA;
                        end
                        ST_DATA: begin
                            if (isWrite)
                                regs[addr] <= (regs[addr] & ~write_mask(addr)) |
                                              (byteIn & write_mask(addr));
                            shiftOut <= read_view(addr + 4'h1);
                            addr     <= addr + 4'h1;
                            remain   <= remain - 4'h1;
                            if (remain == 4'h0)
                                state <= ST_OP1;
                        end
                        default: state <= ST_OP1;
                    endcase
                end
            end
        end
    end

    // serial output: released when deselected, shows ready when idle in continuous mode
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            doutO   <= 1'b0;
            doutOeN <= 1'b1;
        end else begin
            doutOeN <= csNS;
            if (state == ST_DATA && !isWrite)
                doutO <= shiftOut[7];
            else
                doutO <= continuousRead ? resultReadyN : 1'b0;
        end
    end

    // sync clock: a divided enable, held low while disabled
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncDiv         <= 2'h0;
            syncClockOutput <= 1'b0;
        end else begin
            syncDiv <= syncDiv + 2'h1;
            if (!regs[2][5])
                syncClockOutput <= 1'b0;
            else if (syncDiv == 2'h3)
                syncClockOutput <= ~syncClockOutput;
        end
    end

    // decoded configuration fields toward the datapath
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            refBiasEnable        <= 1'b1;
            timeoutEnable        <= 1'b1;
            flagEnable           <= 1'b0;
            sumByteEnable        <= 1'b0;
            filterOrderSelect    <= 1'b0;
            outsideRefSelect     <= 1'b1;
            startDelayCode       <= 3'h0;
            startDelayCycles     <= 13'h0000;
            pulseControl         <= 1'b0;
            outputRateCode       <= 3'h0;
            offsetCorrectionWord <= 24'h000000;
            gainCorrectionWord   <= 24'h400000;
            startLevel           <= 1'b0;
            powerdown            <= 1'b0;
        end else begin
            refBiasEnable     <= regs[0][2];
            timeoutEnable     <= regs[0][0];
            flagEnable        <= regs[1][7] & outOfRange;
            sumByteEnable     <= regs[1][6];
            filterOrderSelect <= regs[1][4];
            outsideRefSelect  <= regs[1][3];
            startDelayCode    <= regs[1][2:0];
            startDelayCycles  <= (regs[1][2:0] == 3'h0) ? 13'h0000 :
                                 (`ACRB_DELAY_BASE << (regs[1][2:0] - 3'h1));
            pulseControl      <= regs[2][4];
            outputRateCode    <= regs[2][2:0];
            offsetCorrectionWord <= {regs[5], regs[4], regs[3]};
            gainCorrectionWord   <= {regs[8], regs[7], regs[6]};
            startLevel        <= syncB[3];
            powerdown         <= ~syncB[4];
        end
    end

endmodule // acrb_register_bank

// ---- shared/acrb_defs.vh ----
// acrb_defs.vh: register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the register bank module
`ifndef ACRB_DEFS_VH
`define ACRB_DEFS_VH
`define ACRB_ADDR_CFG0        4'h0
`define ACRB_ADDR_CFG1        4'h1
`define ACRB_ADDR_CFG2        4'h2
`define ACRB_ADDR_OFS_LOW     4'h3
`define ACRB_ADDR_OFS_MID     4'h4
`define ACRB_ADDR_OFS_HIGH    4'h5
`define ACRB_ADDR_GAIN_LOW    4'h6
`define ACRB_ADDR_GAIN_MID    4'h7
`define ACRB_ADDR_GAIN_HIGH   4'h8
`define ACRB_LAST_ADDR        4'h8
`define ACRB_CMD_READ         4'h2
`define ACRB_CMD_WRITE        4'h4
`define ACRB_CMD_STOP_CONT    8'h11
`define ACRB_CMD_CONT         8'h10
`define ACRB_CMD_RESET_HI     7'h03
`define ACRB_CFG0_RST         8'h85
`define ACRB_CFG0_WMASK       8'h05
`define ACRB_CFG1_RST         8'h08
`define ACRB_CFG1_WMASK       8'hdf
`define ACRB_CFG2_RST         8'h00
`define ACRB_CFG2_WMASK       8'h37
`define ACRB_ZERO_RST         8'h00
`define ACRB_GAIN_HIGH_RST    8'h40
`define ACRB_TIMEOUT_CYCLES   17'h10000
`define ACRB_DELAY_BASE       13'h0040
`endif

// ---- verification/acrb_register_bank_properties.sv ----
// acrb_register_bank_properties.sv: pin-level timing checks for the register bank
// assumes a single sys_clk domain and an asynchronous active-high rst
`timescale 1ns/1ps

module acrb_register_bank_properties (
    input wire        sys_clk,
    input wire        rst,
    input wire        csN,
    input wire        sclk,
    input wire        startPin,
    input wire        resetPowerdownN,
    input wire        outOfRange,
    input wire        doutOeN,
    input wire        syncClockOutput,
    input wire        refBiasEnable,
    input wire        timeoutEnable,
    input wire        flagEnable,
    input wire        outsideRefSelect,
    input wire [2:0]  startDelayCode,
    input wire [12:0] startDelayCycles,
    input wire [23:0] gainCorrectionWord,
    input wire        startLevel,
    input wire        powerdown,
    input wire        spiTimeout
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // deselect held past the pin synchroniser and the output flop
    sequence deselected;
        csN [*6];
    endsequence
    // one full high phase of the divided sync clock
    sequence syncHighPhase;
        syncClockOutput [*4];
    endsequence

    chk_dout_released: assert property (deselected |-> doutOeN)
        else $error("data out driven while deselected");
    chk_sync_period: assert property (syncHighPhase |=> !syncClockOutput)
        else $error("sync clock high phase too long");
    chk_delay_map: assert property ($stable(startDelayCode) |-> startDelayCycles ==
        ((startDelayCode == 3'h0) ? 13'h0 : (13'h40 << (startDelayCode - 3'h1))))
        else $error("start delay count does not match code");
    chk_reset_values: assert property ($fell(rst) |-> refBiasEnable && timeoutEnable
        && outsideRefSelect && gainCorrectionWord == 24'h400000)
        else $error("field not at reset value");
    chk_timeout_cause: assert property (spiTimeout |-> timeoutEnable && !sclk ##1 !spiTimeout)
        else $error("timeout pulse without enable or held clock");
    chk_flag_gate: assert property (!outOfRange [*3] |-> !flagEnable)
        else $error("out-of-range flag without cause");
    chk_powerdown_follow: assert property ($stable(resetPowerdownN) [*5] |-> powerdown == !resetPowerdownN)
        else $error("powerdown does not follow its pin");
    chk_start_follow: assert property ($stable(startPin) [*5] |-> startLevel == startPin)
        else $error("start level does not follow its pin");
endmodule // acrb_register_bank_properties

bind acrb_register_bank acrb_register_bank_properties u_chk (
    .sys_clk, .rst, .csN, .sclk, .startPin, .resetPowerdownN, .outOfRange, .doutOeN,
    .syncClockOutput, .refBiasEnable, .timeoutEnable, .flagEnable, .outsideRefSelect,
    .startDelayCode, .startDelayCycles, .gainCorrectionWord, .startLevel, .powerdown,
    .spiTimeout
);

// ---- verification/acrb_host_model.sv ----
// acrb_host_model.sv: serial bus controller framing commands for the register bank
// assumes the bench resolves the data out line and calls frame and xfer in turn
`timescale 1ns/1ps

module acrb_host_model (
    input  wire sys_clk,
    input  wire doutLine,
    output reg  csN,
    output reg  sclk,
    output reg  din
);
    // idle: deselected, link clock parked low between frames
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // select moves on a falling edge, then waits out the pin synchroniser
    task frame(input on);
        begin
            @(negedge sys_clk);
            csN = ~on;
            repeat (4) @(negedge sys_clk);
        end
    endtask

    // one byte msb first at 48 ns; output bits are taken midway through the low phase so the
    // read path latency never eats the sample window; the last bit is taken just before
    // its falling edge, since that edge loads the next register into the shifter
    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                #12 din = tx[i];
                if (i < 7) rx[i + 1] = doutLine;
                #12 sclk = 1'b1;
                #24;
                if (i == 0) rx[0] = doutLine;
                sclk = 1'b0;
            end
            // keep select low until the last falling edge has passed the synchroniser
            #24;
        end
    endtask
endmodule // acrb_host_model

// ---- verification/acrb_register_bank_tb.sv ----
// acrb_register_bank_tb.sv: random register traffic checked against a bench model
// assumes the host model owns csN, sclk and din; a pull-down holds the released line
`timescale 1ns/1ps
`include "acrb_defs.vh"

module acrb_register_bank_tb;
    localparam [1:0] IDF = 2'h2; // arbitrary identity value
    logic       sys_clk, rst, startPin, resetPowerdownN, clkSourceExt, resultReadyN, outOfRange;
    wire        csN, sclk, din, doutO, doutOeN, syncClockOutput, refBiasEnable, timeoutEnable;
    wire        flagEnable, sumByteEnable, filterOrderSelect, outsideRefSelect, pulseControl;
    wire        startLevel, powerdown, continuousRead, spiTimeout, doutLine;
    wire [2:0]  startDelayCode, outputRateCode;
    wire [12:0] startDelayCycles;
    wire [23:0] offsetCorrectionWord, gainCorrectionWord;
    logic [7:0] mdl [0:8];
    logic [7:0] wbuf [0:9];
    logic [7:0] rx;
    logic       cont, hit;
    integer     fail_count, compares, k, j;

    acrb_register_bank #(.IDENTITY_FIELD(IDF), .TIMEOUT_CYCLES(17'h40)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .csN(csN), .sclk(sclk), .din(din),
        .startPin(startPin), .resetPowerdownN(resetPowerdownN), .clkSourceExt(clkSourceExt),
        .resultReadyN(resultReadyN), .outOfRange(outOfRange), .doutO(doutO),
        .doutOeN(doutOeN), .syncClockOutput(syncClockOutput), .refBiasEnable(refBiasEnable),
        .timeoutEnable(timeoutEnable), .flagEnable(flagEnable), .sumByteEnable(sumByteEnable),
        .filterOrderSelect(filterOrderSelect), .outsideRefSelect(outsideRefSelect),
        .startDelayCode(startDelayCode), .startDelayCycles(startDelayCycles),
        .pulseControl(pulseControl), .outputRateCode(outputRateCode),
        .offsetCorrectionWord(offsetCorrectionWord), .gainCorrectionWord(gainCorrectionWord),
        .startLevel(startLevel), .powerdown(powerdown), .continuousRead(continuousRead),
        .spiTimeout(spiTimeout));
    acrb_host_model u_host (.sys_clk(sys_clk), .doutLine(doutLine), .csN(csN), .sclk(sclk),
                            .din(din));
    // pull-down keeps the released data line at a known level
    assign doutLine = doutOeN ? 1'b0 : doutO;
    always #2.5 sys_clk = ~sys_clk;

    task check(input [23:0] seen, input [23:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("comparisons %0d, mismatches %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // bench copy of the registers after power-up or the reset command
    task mreset;
        begin
            for (j = 0; j < 9; j = j + 1) mdl[j] = 8'h00;
            mdl[0] = 8'h05;
            mdl[1] = 8'h08;
            mdl[8] = 8'h40;
            cont = 1'b1;
        end
    endtask
    function [7:0] wmask(input [3:0] a);
        wmask = (a == 4'h0) ? `ACRB_CFG0_WMASK : (a == 4'h1) ? `ACRB_CFG1_WMASK :
                (a == 4'h2) ? `ACRB_CFG2_WMASK : 8'hff;
    endfunction
    function [7:0] expv(input [3:0] a);
        if (a == 4'h0) expv = {2'b10, IDF, mdl[0][3:0]};
        else if (a == 4'h2) expv = {resultReadyN, clkSourceExt, mdl[2][5:0]};
        else if (a > 4'h8) expv = 8'h00;
        else expv = mdl[a];
    endfunction
    task op(input [7:0] b);
        begin
            u_host.frame(1'b1);
            u_host.xfer(b, rx);
            u_host.frame(1'b0);
            if (b == `ACRB_CMD_STOP_CONT) cont = 1'b0;
        end
    endtask
    // write n bytes from wbuf; refused while continuous read is on
    task wburst(input [3:0] a, input integer n);
        begin
            u_host.frame(1'b1);
            u_host.xfer({4'h4, a}, rx);
            u_host.xfer(8'(n - 1), rx);
            for (j = 0; j < n; j = j + 1) begin
                u_host.xfer(wbuf[j], rx);
                if (!cont && a + j < 9) mdl[a + j] = wbuf[j] & wmask(a + j);
            end
            u_host.frame(1'b0);
        end
    endtask
    task rdchk(input [3:0] a, input integer n);
        begin
            u_host.frame(1'b1);
            u_host.xfer({4'h2, a}, rx);
            u_host.xfer(8'(n - 1), rx);
            for (j = 0; j < n; j = j + 1) begin
                u_host.xfer(8'h00, rx);
                check(rx, expv(a + j));
            end
            u_host.frame(1'b0);
        end
    endtask

    // hang guard: the whole run needs well under 200 us
    initial begin
        #400000;
        fail_count = fail_count + 1;
        stop_test;
    end
    // main sequence
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        startPin = 1'b0;
        resetPowerdownN = 1'b1;
        clkSourceExt = 1'b0;
        resultReadyN = 1'b1;
        outOfRange = 1'b0;
        fail_count = 0;
        compares = 0;
        k = $urandom(32'h8865ce7c);
        mreset;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk) rst = 1'b0;
        // selected and idle in continuous mode the data line shows ready (high here)
        u_host.frame(1'b1);
        check(doutLine, resultReadyN);
        u_host.frame(1'b0);
        wbuf[0] = 8'h00;
        wburst(4'h0, 1);
        check(refBiasEnable, 1'b1);
        op(`ACRB_CMD_STOP_CONT);
        check(continuousRead, 1'b0);
        rdchk(4'h0, 10);
        $display("test reset values and refusal done");
        // random bursts over all nine registers plus one unmapped; round k sets codes k
        for (k = 0; k < 8; k = k + 1) begin
            for (j = 0; j < 10; j = j + 1) wbuf[j] = $urandom;
            {wbuf[0][3], wbuf[0][1], wbuf[1][5], wbuf[2][3]} = 4'h0;
            wbuf[1][2:0] = k[2:0];
            wbuf[2][2:0] = k[2:0];
            @(negedge sys_clk);
            {startPin, clkSourceExt, resultReadyN, outOfRange} = 4'($urandom);
            wburst(4'h0, 10);
            rdchk(4'h0, 10);
            check(offsetCorrectionWord, {mdl[5], mdl[4], mdl[3]});
            check(gainCorrectionWord, {mdl[8], mdl[7], mdl[6]});
            check({refBiasEnable, timeoutEnable, sumByteEnable, filterOrderSelect},
                  {mdl[0][2], mdl[0][0], mdl[1][6], mdl[1][4]});
            check({outsideRefSelect, pulseControl}, {mdl[1][3], mdl[2][4]});
            check(startDelayCycles, (k == 0) ? 24'h0 : (24'h40 << (k - 1)));
            check(outputRateCode, k[2:0]);
            check(startDelayCode, k[2:0]);
            check(flagEnable, mdl[1][7] & outOfRange);
            check(startLevel, startPin);
            hit = 1'b0;
            repeat (16) @(negedge sys_clk) hit = hit | syncClockOutput;
            check(hit, mdl[2][5]);
            $display("test random burst %0d done", k);
        end
        // command cut short by deselect, then the reset command
        u_host.frame(1'b1);
        u_host.xfer({4'h4, 4'h3}, rx);
        u_host.frame(1'b0);
        check(doutOeN, 1'b1);
        rdchk(4'h3, 1);
        op(8'h06);
        mreset;
        op(`ACRB_CMD_STOP_CONT);
        rdchk(4'h0, 9);
        $display("test abort and reset command done");
        // selected with the link clock parked low until the timeout fires
        u_host.frame(1'b1);
        hit = 1'b0;
        repeat (100) @(negedge sys_clk) hit = hit | spiTimeout;
        u_host.frame(1'b0);
        check(hit, 1'b1);
        @(negedge sys_clk);
        resetPowerdownN = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(powerdown, 1'b1);
        $display("test timeout and power-down done");
        stop_test;
    end
endmodule // acrb_register_bank_tb
